// File: verilog/fmv_params.svh
// fmv_params.svh: offsets, field positions, codes and reset values
`ifndef FMV_PARAMS_SVH
`define FMV_PARAMS_SVH

// =====================================================================
// register offsets (word index on the register port)
`define FMV_OFS_STAT 3'h0
`define FMV_OFS_INDEX 3'h1
`define FMV_OFS_PARAM 3'h2
`define FMV_OFS_MODE 3'h3

// =====================================================================
// status bit positions
`define FMV_BIT_COMMAND_COMPLETE_FLAG 7
`define FMV_BIT_ACCESS_ERROR_FLAG 5
`define FMV_BIT_PROTECTION_VIOLATION_FLAG 4
`define FMV_BIT_VERR 1
`define FMV_BIT_VUNC 0
`define FMV_BIT_SPECIAL 0

// =====================================================================
// reset values
`define FMV_RST_COMMAND_COMPLETE_FLAG 1'b1
`define FMV_RST_INDEX 3'h0
`define FMV_RST_MODE 1'b0
`define FMV_RST_SLOT 16'h0000
`define FMV_RST_LEVEL 3'h0

// =====================================================================
// command codes and parameter slot layout
`define FMV_CMD_USER 8'h0d
`define FMV_CMD_FIELD 8'h0e
`define FMV_CMD_VERIFY 8'h10
`define FMV_IDX_MARGIN 3'h1
`define FMV_IDX_VERIFY 3'h2
`define FMV_LVL_USER_MAX 16'h0002
`define FMV_LVL_FIELD_MAX 16'h0004

// =====================================================================
// flash block map
`define FMV_NUM_BLOCKS 5
`define FMV_DBLK_ID 7'h10
`define FMV_PBLK_BASE 7'h7c
`define FMV_DFLASH_BYTES 17'h08000
`define FMV_ERASED 16'hffff

`endif

// File: verilog/fmv_pkg.sv
// fmv_pkg.sv: types shared by the margin and verify sequencer
package fmv_pkg;

  // =====================================================================
  // sequencer states
  typedef enum logic [1:0] {
    FMV_IDLE = 2'b00,
    FMV_EVAL = 2'b01,
    FMV_VREQ = 2'b10,
    FMV_VWAIT = 2'b11
  } fmv_state_t;

  // =====================================================================
  // decoded command taken from the parameter slots
  typedef struct packed {
    logic [7:0] code;
    logic [6:0] blk;
    logic [15:0] addr;
    logic [15:0] count;
  } fmv_cmd_t;

endpackage : fmv_pkg

// File: verilog/fmv_param_file.sv
// fmv_param_file.sv: indexed command parameter slots
`timescale 1ns/1ps
`include "fmv_params.svh"

module fmv_param_file (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // write and read by index
  input wire logic i_wr,
  input wire logic [2:0] i_idx,
  input wire logic [15:0] i_wdata,
  output logic [15:0] o_rdata,
  // first three slots for the sequencer
  output logic [15:0] o_slot0,
  output logic [15:0] o_slot1,
  output logic [15:0] o_slot2
);

  logic [15:0] slot_reg [8];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < 8; i++) begin
        slot_reg[i] <= `FMV_RST_SLOT;
      end
    end else if (i_wr) begin
      slot_reg[i_idx] <= i_wdata;
    end
  end

  assign o_rdata = slot_reg[i_idx];
  assign o_slot0 = slot_reg[0];
  assign o_slot1 = slot_reg[1];
  assign o_slot2 = slot_reg[2];

endmodule : fmv_param_file

// File: verilog/fmv_margin_store.sv
// fmv_margin_store.sv: read margin level held per flash block
`timescale 1ns/1ps
`include "fmv_params.svh"

module fmv_margin_store #(
  parameter int NBLK = `FMV_NUM_BLOCKS,
  parameter int IW = $clog2(NBLK)
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // level update
  input wire logic i_wr,
  input wire logic [IW-1:0] i_wr_idx,
  input wire logic [2:0] i_wr_level,
  // registered level lookup
  input wire logic [IW-1:0] i_rd_idx,
  output logic [2:0] o_rd_level
);

  logic [2:0] level_reg [NBLK];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      for (int i = 0; i < NBLK; i++) begin
        level_reg[i] <= `FMV_RST_LEVEL;
      end
    end else if (i_wr) begin
      level_reg[i_wr_idx] <= i_wr_level;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rd_level <= `FMV_RST_LEVEL;
    end else begin
      o_rd_level <= level_reg[i_rd_idx];
    end
  end

endmodule : fmv_margin_store

// File: verilog/fmv_sequencer.sv
// fmv_sequencer.sv: margin level and section erase verify sequencer
//
// How it works
// - code 0x0d sets user margin; slot 0 block, slot 1 level
// - user margin is stored for the block, then complete flag sets
// - user margin accepts only levels 0, 1 and 2
// - margin commands need index 001 at launch, else access error
// - commands not allowed in the current mode raise access error
// - margin commands with an unknown block raise access error
// - margin commands with a disallowed level raise access error
// - code 0x0e sets field margin, special mode only
// - field margin is stored for the block, then complete flag sets
// - field margin accepts only levels 0 to 4
// - code 0x10 verifies a D-flash section: block, start, word count
// - verify reads each word, checks erased, then sets complete flag
// - verify needs index 010 at launch, else access error
// - verify start outside the D-flash raises access error
// - verify start with address bit 0 set raises access error
// - verify section running past the D-flash end raises access error
// - any read error during verify sets the verify error flag
// - an uncorrectable read during verify sets the uncorrectable flag
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "fmv_params.svh"

module fmv_sequencer #(
  parameter int NBLK = `FMV_NUM_BLOCKS,
  parameter logic [16:0] DFLASH_BYTES = `FMV_DFLASH_BYTES
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RESET,
  // register port
  input wire logic [2:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [15:0] O_RDATA,
  // flash array read port
  output logic O_FLASH_RD,
  output logic [22:0] O_FLASH_ADDR,
  input wire logic I_FLASH_VALID,
  input wire logic [15:0] I_FLASH_RDATA,
  input wire logic I_FLASH_ECC_FIX,
  input wire logic I_FLASH_ECC_BAD,
  // margin for reads of a block
  input wire logic [6:0] I_READ_BLK,
  output logic [2:0] O_FLASH_MARGIN,
  // command state
  output logic O_CMD_DONE
);

  localparam int IW = $clog2(NBLK);

  // =====================================================================
  // block map helpers
  function automatic logic blk_valid(input logic [6:0] b);
    blk_valid = (b == `FMV_DBLK_ID) ||
      (({1'b0, b} >= {1'b0, `FMV_PBLK_BASE}) &&
       ({1'b0, b} < ({1'b0, `FMV_PBLK_BASE} + 8'(NBLK - 1))));
  endfunction : blk_valid

  function automatic logic [IW-1:0] blk_index(input logic [6:0] b);
    logic [6:0] d;
    d = b - `FMV_PBLK_BASE + 7'h01;
    if (b == `FMV_DBLK_ID || !blk_valid(b)) begin
      blk_index = '0;
    end else begin
      blk_index = d[IW-1:0];
    end
  endfunction : blk_index

  // =====================================================================
  // state
  fmv_pkg::fmv_state_t st_reg;
  fmv_pkg::fmv_cmd_t cmd;
  logic command_complete_flag_reg;
  logic access_error_flag_reg;
  logic verr_reg;
  logic vunc_reg;
  logic special_reg;
  logic [2:0] index_reg;
  logic [15:0] rdata_reg;
  logic [15:0] cur_reg;
  logic [15:0] left_reg;
  logic rd_reg;
  logic [22:0] faddr_reg;
  logic [15:0] slot0;
  logic [15:0] slot1;
  logic [15:0] slot2;
  logic [15:0] slot_rdata;
  logic launch;
  logic is_margin;
  logic cmd_err;
  logic margin_wr;
  logic [17:0] sect_end;
  logic last_word;
  logic word_bad;

  assign launch = I_WR && I_ADDR == `FMV_OFS_STAT &&
    I_WDATA[`FMV_BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg && !access_error_flag_reg;

  // =====================================================================
  // parameter slots; writes are ignored while a command runs
  fmv_param_file u_param (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    .i_wr(I_WR && I_ADDR == `FMV_OFS_PARAM && command_complete_flag_reg),
    .i_idx(index_reg),
    .i_wdata(I_WDATA),
    .o_rdata(slot_rdata),
    .o_slot0(slot0),
    .o_slot1(slot1),
    .o_slot2(slot2)
  );

  assign cmd = '{code: slot0[15:8], blk: slot0[6:0],
                 addr: slot1, count: slot2};

  // =====================================================================
  // launch checks
  always_comb begin
    is_margin = cmd.code == `FMV_CMD_USER || cmd.code == `FMV_CMD_FIELD;
    sect_end = {2'b00, cmd.addr} + {1'b0, cmd.count, 1'b0};
    cmd_err = 1'b1;
    unique case (cmd.code)
      `FMV_CMD_USER: begin
        cmd_err = index_reg != `FMV_IDX_MARGIN || !blk_valid(cmd.blk) ||
          cmd.addr > `FMV_LVL_USER_MAX;
      end
      `FMV_CMD_FIELD: begin
        cmd_err = !special_reg || index_reg != `FMV_IDX_MARGIN ||
          !blk_valid(cmd.blk) || cmd.addr > `FMV_LVL_FIELD_MAX;
      end
      // address in the D-flash, word aligned
      `FMV_CMD_VERIFY: begin
        cmd_err = index_reg != `FMV_IDX_VERIFY ||
          cmd.blk != `FMV_DBLK_ID ||
          {1'b0, cmd.addr} >= DFLASH_BYTES || cmd.addr[0] ||
          sect_end > {1'b0, DFLASH_BYTES};
      end
      default: begin
        cmd_err = 1'b1;
      end
    endcase
  end

  // margin table untouched on any error
  assign margin_wr = st_reg == fmv_pkg::FMV_EVAL && is_margin && !cmd_err;
  assign last_word = left_reg == 16'h0001;
  assign word_bad = I_FLASH_RDATA != `FMV_ERASED || I_FLASH_ECC_FIX ||
    I_FLASH_ECC_BAD;

  // =====================================================================
  // per-block margin levels; verify reads use the D-flash level
  fmv_margin_store #(
    .NBLK(NBLK),
    .IW(IW)
  ) u_margin (
    .i_clk(I_SYS_CLK),
    .i_reset(I_RESET),
    // apply level to the addressed block
    .i_wr(margin_wr),
    .i_wr_idx(blk_index(cmd.blk)),
    .i_wr_level(cmd.addr[2:0]),
    .i_rd_idx(st_reg == fmv_pkg::FMV_IDLE ? blk_index(I_READ_BLK) :
              blk_index(`FMV_DBLK_ID)),
    .o_rd_level(O_FLASH_MARGIN)
  );

  // =====================================================================
  // sequencer
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      st_reg <= fmv_pkg::FMV_IDLE;
    end else begin
      unique case (st_reg)
        fmv_pkg::FMV_IDLE: begin
          // clearing the complete flag starts the command
          if (launch) begin
            st_reg <= fmv_pkg::FMV_EVAL;
          end
        end
        fmv_pkg::FMV_EVAL: begin
          if (!cmd_err && cmd.code == `FMV_CMD_VERIFY &&
              cmd.count != 16'h0000) begin
            st_reg <= fmv_pkg::FMV_VREQ;
          end else begin
            st_reg <= fmv_pkg::FMV_IDLE;
          end
        end
        fmv_pkg::FMV_VREQ: begin
          st_reg <= fmv_pkg::FMV_VWAIT;
        end
        fmv_pkg::FMV_VWAIT: begin
          if (I_FLASH_VALID) begin
            st_reg <= last_word ? fmv_pkg::FMV_IDLE : fmv_pkg::FMV_VREQ;
          end
        end
      endcase
    end
  end

  // walk the section one word at a time
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      cur_reg <= 16'h0000;
      left_reg <= 16'h0000;
      rd_reg <= 1'b0;
      faddr_reg <= 23'h000000;
    end else begin
      rd_reg <= st_reg == fmv_pkg::FMV_VREQ;
      if (st_reg == fmv_pkg::FMV_EVAL) begin
        cur_reg <= cmd.addr;
        left_reg <= cmd.count;
      end else if (st_reg == fmv_pkg::FMV_VWAIT && I_FLASH_VALID) begin
        cur_reg <= cur_reg + 16'h0002;
        left_reg <= left_reg - 16'h0001;
      end
      if (st_reg == fmv_pkg::FMV_VREQ) begin
        faddr_reg <= {`FMV_DBLK_ID, cur_reg};
      end
    end
  end

  assign O_FLASH_RD = rd_reg;
  assign O_FLASH_ADDR = faddr_reg;

  // =====================================================================
  // complete flag
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      command_complete_flag_reg <= `FMV_RST_COMMAND_COMPLETE_FLAG;
    end else if (launch) begin
      command_complete_flag_reg <= 1'b0;
    end else if (st_reg == fmv_pkg::FMV_EVAL &&
                 (cmd_err || cmd.code != `FMV_CMD_VERIFY ||
                  cmd.count == 16'h0000)) begin
      // errors and margin commands finish here
      command_complete_flag_reg <= 1'b1;
    end else if (st_reg == fmv_pkg::FMV_VWAIT && I_FLASH_VALID &&
                 last_word) begin
      command_complete_flag_reg <= 1'b1;
    end
  end

  assign O_CMD_DONE = command_complete_flag_reg;

  // =====================================================================
  // error flags; a new error wins over a software clear
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      access_error_flag_reg <= 1'b0;
    end else if (st_reg == fmv_pkg::FMV_EVAL && cmd_err) begin
      // mode, index, block, level and range faults
      access_error_flag_reg <= 1'b1;
    end else if (I_WR && I_ADDR == `FMV_OFS_STAT &&
                 I_WDATA[`FMV_BIT_ACCESS_ERROR_FLAG]) begin
      access_error_flag_reg <= 1'b0;
    end
  end

  // verify results clear at each launch and only read during verify
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      verr_reg <= 1'b0;
      vunc_reg <= 1'b0;
    end else if (launch) begin
      verr_reg <= 1'b0;
      vunc_reg <= 1'b0;
    end else if (st_reg == fmv_pkg::FMV_VWAIT && I_FLASH_VALID) begin
      // not erased or any ecc event
      if (word_bad) begin
        verr_reg <= 1'b1;
      end
      if (I_FLASH_ECC_BAD) begin
        vunc_reg <= 1'b1;
      end
    end
  end

  // =====================================================================
  // index, mode and read data
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET) begin
      index_reg <= `FMV_RST_INDEX;
      special_reg <= `FMV_RST_MODE;
    end else if (I_WR && command_complete_flag_reg) begin
      if (I_ADDR == `FMV_OFS_INDEX) begin
        index_reg <= I_WDATA[2:0];
      end
      if (I_ADDR == `FMV_OFS_MODE) begin
        special_reg <= I_WDATA[`FMV_BIT_SPECIAL];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RESET || !I_RD) begin
      rdata_reg <= 16'h0000;
    end else begin
      unique case (I_ADDR)
        `FMV_OFS_STAT: begin
          rdata_reg <= 16'h0000;
          rdata_reg[`FMV_BIT_COMMAND_COMPLETE_FLAG] <= command_complete_flag_reg;
          rdata_reg[`FMV_BIT_ACCESS_ERROR_FLAG] <= access_error_flag_reg;
          rdata_reg[`FMV_BIT_VERR] <= verr_reg;
          rdata_reg[`FMV_BIT_VUNC] <= vunc_reg;
        end
        `FMV_OFS_INDEX: rdata_reg <= {13'h0000, index_reg};
        `FMV_OFS_PARAM: rdata_reg <= slot_rdata;
        `FMV_OFS_MODE: rdata_reg <= {15'h0000, special_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end

  assign O_RDATA = rdata_reg;

  // =====================================================================
  // checks
  user_apply_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    margin_wr && cmd.code == `FMV_CMD_USER |->
    cmd.addr <= `FMV_LVL_USER_MAX ##1 command_complete_flag_reg)
    else $error("user margin not applied cleanly");

  user_level_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    st_reg == fmv_pkg::FMV_EVAL && cmd.code == `FMV_CMD_USER &&
    cmd.addr > `FMV_LVL_USER_MAX |=> access_error_flag_reg && command_complete_flag_reg)
    else $error("bad user level accepted");

  margin_index_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    st_reg == fmv_pkg::FMV_EVAL && is_margin &&
    index_reg != `FMV_IDX_MARGIN |=> access_error_flag_reg)
    else $error("margin index fault missed");

  field_mode_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    st_reg == fmv_pkg::FMV_EVAL && cmd.code == `FMV_CMD_FIELD &&
    !special_reg |-> !margin_wr ##1 access_error_flag_reg)
    else $error("field margin ran outside special mode");

  margin_blk_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    st_reg == fmv_pkg::FMV_EVAL && is_margin &&
    !blk_valid(cmd.blk) |=> access_error_flag_reg)
    else $error("unknown block accepted");

  field_level_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    margin_wr && cmd.code == `FMV_CMD_FIELD |->
    cmd.addr <= `FMV_LVL_FIELD_MAX && special_reg ##1 command_complete_flag_reg)
    else $error("field level out of range applied");

  verify_index_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    st_reg == fmv_pkg::FMV_EVAL && cmd.code == `FMV_CMD_VERIFY &&
    index_reg != `FMV_IDX_VERIFY |=> access_error_flag_reg ##1 !O_FLASH_RD)
    else $error("verify index fault missed");

  verify_range_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    st_reg == fmv_pkg::FMV_EVAL && cmd.code == `FMV_CMD_VERIFY &&
    (cmd.addr[0] || sect_end > {1'b0, DFLASH_BYTES}) |=> access_error_flag_reg)
    else $error("misaligned or overlong section accepted");

  verify_flag_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    st_reg == fmv_pkg::FMV_VWAIT && I_FLASH_VALID &&
    word_bad |=> verr_reg && (vunc_reg == $past(I_FLASH_ECC_BAD) ||
    $past(vunc_reg)))
    else $error("verify error not flagged");

  skip_op_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RESET)
    launch ##1 cmd_err |-> !margin_wr ##1
    command_complete_flag_reg && st_reg == fmv_pkg::FMV_IDLE)
    else $error("faulty command not skipped");

endmodule : fmv_sequencer

// File: bench/fmv_flash_model.sv
// fmv_flash_model.sv: behavioural flash array answering word reads
`timescale 1ns/1ps

module fmv_flash_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // read request
  input wire logic i_rd,
  input wire logic [22:0] i_addr,
  // answer delay and fault injection
  input wire logic [3:0] i_lat,
  input wire logic [15:0] i_bad_addr,
  input wire logic [1:0] i_bad_kind,
  // answer
  output logic o_valid,
  output logic [15:0] o_rdata,
  output logic o_fix,
  output logic o_bad
);
  logic busy;
  logic [3:0] wait_cnt;
  logic [15:0] addr_q;

  // =====================================================================
  // one read at a time; data lines wander while no answer stands
  always_ff @(posedge i_clk) begin
    o_valid <= 1'b0;
    o_fix <= 1'b0;
    o_bad <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_reset) begin
      busy <= 1'b0;
      wait_cnt <= 4'h0;
      o_rdata <= 16'h5a5a;
    end else if (i_rd) begin
      busy <= 1'b1;
      wait_cnt <= i_lat;
      addr_q <= i_addr[15:0];
    end else if (busy && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (busy) begin
      busy <= 1'b0;
      o_valid <= 1'b1;
      o_rdata <= 16'hffff;
      if (addr_q == i_bad_addr) begin
        o_rdata <= (i_bad_kind == 2'h1) ? 16'h0000 : 16'hffff;
        o_fix <= (i_bad_kind == 2'h2);
        o_bad <= (i_bad_kind == 2'h3);
      end
    end
  end
endmodule : fmv_flash_model

// File: bench/fmv_sequencer_tb.sv
// fmv_sequencer_tb.sv: self-checking bench for the margin and verify block
`timescale 1ns/1ps
`include "fmv_params.svh"

module fmv_sequencer_tb;
  logic clk;
  logic rst;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic f_rd;
  logic [22:0] f_addr;
  logic f_valid;
  logic [15:0] f_data;
  logic f_fix;
  logic f_bad;
  logic [6:0] read_blk;
  logic [2:0] margin;
  logic done;
  logic [3:0] lat;
  logic [15:0] bad_addr;
  logic [1:0] bad_kind;
  logic special;
  logic [2:0] lvl [0:127];
  logic [15:0] exp_addr;
  int nrd;
  int miscompares;
  int checks_done;

  fmv_sequencer dut (.I_SYS_CLK(clk), .I_RESET(rst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_FLASH_RD(f_rd), .O_FLASH_ADDR(f_addr), .I_FLASH_VALID(f_valid),
    .I_FLASH_RDATA(f_data), .I_FLASH_ECC_FIX(f_fix),
    .I_FLASH_ECC_BAD(f_bad), .I_READ_BLK(read_blk),
    .O_FLASH_MARGIN(margin), .O_CMD_DONE(done));

  fmv_flash_model flash (.i_clk(clk), .i_reset(rst), .i_rd(f_rd),
    .i_addr(f_addr), .i_lat(lat), .i_bad_addr(bad_addr),
    .i_bad_kind(bad_kind), .o_valid(f_valid), .o_rdata(f_data),
    .o_fix(f_fix), .o_bad(f_bad));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // =====================================================================
  // comparison, verdict and register bus tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // =====================================================================
  // expected launch outcome
  function automatic logic acc_exp(input logic [7:0] c, input logic [6:0] b,
      input logic [2:0] ix, input logic [15:0] p1, input logic [15:0] p2);
    logic bok;
    bok = (b == 7'h10) || (b >= 7'h7c);
    case (c)
      `FMV_CMD_USER: return ix != 3'h1 || !bok || p1 > 16'h0002;
      `FMV_CMD_FIELD: return !special || ix != 3'h1 || !bok || p1 > 16'h0004;
      `FMV_CMD_VERIFY: return ix != 3'h2 || b != 7'h10 || p1 >= 16'h8000
        || p1[0] || (32'(p1) + 2 * 32'(p2)) > 32'h8000;
      default: return 1'b1;
    endcase
  endfunction : acc_exp

  // every read of a verify walks the section word by word
  always @(posedge clk) begin
    if (f_rd === 1'b1) begin
      check({9'h0, f_addr[22:16]}, 16'h0010);
      check(f_addr[15:0], exp_addr);
      exp_addr = exp_addr + 16'h0002;
      nrd++;
    end
  end

  // =====================================================================
  // load slots, launch, wait, then judge status and margin
  task automatic cmd(input logic [7:0] c, input logic [6:0] b,
      input logic [2:0] ix, input logic [15:0] p1, input logic [15:0] p2);
    logic acc;
    logic hit;
    logic [15:0] st;
    int n;
    acc = acc_exp(c, b, ix, p1, p2);
    hit = c == `FMV_CMD_VERIFY && !acc && bad_kind != 2'h0
      && bad_addr >= p1 && 32'(bad_addr) < 32'(p1) + 2 * 32'(p2);
    reg_wr(`FMV_OFS_STAT, 16'h0020);
    reg_wr(`FMV_OFS_INDEX, 16'h0000);
    reg_wr(`FMV_OFS_PARAM, {c, 1'b0, b});
    reg_wr(`FMV_OFS_INDEX, 16'h0001);
    reg_wr(`FMV_OFS_PARAM, p1);
    reg_wr(`FMV_OFS_INDEX, 16'h0002);
    reg_wr(`FMV_OFS_PARAM, p2);
    reg_wr(`FMV_OFS_INDEX, {13'h0, ix});
    exp_addr = p1;
    nrd = 0;
    reg_wr(`FMV_OFS_STAT, 16'h0080);
    #1;
    check({15'h0, done}, 16'h0000);
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (done !== 1'b1) begin
      miscompares++;
      results();
    end
    if (acc) check(16'(n), 16'h0001);
    reg_rd(`FMV_OFS_STAT, st);
    check(st, {10'h002, acc, 3'h0, hit, hit && bad_kind == 2'h3});
    if (c == `FMV_CMD_VERIFY && !acc) check(16'(nrd), p2);
    if (c != `FMV_CMD_VERIFY && !acc) lvl[b] = p1[2:0];
    if (b == 7'h10 || b >= 7'h7c) begin
      @(posedge clk);
      read_blk <= b;
      @(posedge clk);
      #1;
      check({13'h0, margin}, {13'h0, lvl[b]});
    end
  endtask : cmd

  // =====================================================================
  // main sequence
  initial begin
    logic [15:0] st;
    logic [7:0] c;
    logic [6:0] b;
    logic [2:0] ix;
    logic [15:0] p1;
    int r;
    rst = 1'b1;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    read_blk = 7'h10;
    lat = 4'h0;
    bad_addr = 16'h0000;
    bad_kind = 2'h0;
    special = 1'b0;
    miscompares = 0;
    checks_done = 0;
    nrd = 0;
    exp_addr = 16'h0000;
    for (int i = 0; i < 128; i++) lvl[i] = 3'h0;
    void'($urandom(52));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    reg_rd(`FMV_OFS_STAT, st);
    check(st, 16'h0080);
    reg_rd(3'h5, st);
    check(st, 16'h0000);
    reg_wr(`FMV_OFS_INDEX, 16'h0003);
    reg_wr(`FMV_OFS_PARAM, 16'h5a3c);
    reg_rd(`FMV_OFS_PARAM, st);
    check(st, 16'h5a3c);
    reg_rd(`FMV_OFS_INDEX, st);
    check(st, 16'h0003);
    reg_rd(`FMV_OFS_MODE, st);
    check(st, 16'h0000);
    for (int i = 0; i < 4; i++) cmd(8'h0d, 7'h7c + 7'(i), 3'h1, 16'(i), 0);
    cmd(8'h0d, 7'h7f, 3'h2, 16'h0001, 16'h0000);
    cmd(8'h0d, 7'h11, 3'h1, 16'h0001, 16'h0000);
    cmd(8'h0e, 7'h7d, 3'h1, 16'h0003, 16'h0000);
    reg_wr(`FMV_OFS_STAT, 16'h0080);
    #1;
    check({15'h0, done}, 16'h0001);
    // field levels set only in special mode
    reg_wr(`FMV_OFS_MODE, 16'h0001);
    special = 1'b1;
    for (int i = 0; i < 6; i++) cmd(8'h0e, 7'h10, 3'h1, 16'(i), 0);
    cmd(8'h10, 7'h10, 3'h2, 16'h7ffe, 16'h0001);
    cmd(8'h10, 7'h10, 3'h2, 16'h7ffe, 16'h0002);
    cmd(8'h10, 7'h10, 3'h2, 16'h8000, 16'h0000);
    cmd(8'h10, 7'h10, 3'h2, 16'h0003, 16'h0001);
    cmd(8'h10, 7'h10, 3'h1, 16'h0000, 16'h0001);
    cmd(8'h10, 7'h7c, 3'h2, 16'h0000, 16'h0001);
    cmd(8'h10, 7'h10, 3'h2, 16'h0000, 16'h0000);
    cmd(8'h11, 7'h10, 3'h1, 16'h0000, 16'h0000);
    bad_addr = 16'h0104;
    for (int k = 1; k < 4; k++) begin
      bad_kind = 2'(k);
      cmd(8'h10, 7'h10, 3'h2, 16'h0100, 16'h0004);
    end
    for (int i = 0; i < 40; i++) begin
      r = $urandom_range(0, 2);
      c = (r == 0) ? 8'h0d : (r == 1) ? 8'h0e : 8'h10;
      b = (c == 8'h10 || $urandom_range(0, 1)) ? 7'h10
        : 7'h7c + 7'($urandom_range(0, 3));
      if ($urandom_range(0, 4) == 0) b = 7'($urandom);
      ix = (c == 8'h10) ? 3'h2 : 3'h1;
      if ($urandom_range(0, 5) == 0) ix = 3'($urandom);
      p1 = (c != 8'h10) ? 16'($urandom_range(0, 5))
        : ($urandom_range(0, 3) == 0) ? 16'($urandom)
        : 16'h7fe0 + 16'(2 * $urandom_range(0, 15));
      lat = 4'($urandom_range(0, 3));
      bad_addr = p1 + 16'(2 * $urandom_range(0, 9));
      bad_kind = 2'($urandom);
      if ($urandom_range(0, 7) == 0) begin
        special = ~special;
        reg_wr(`FMV_OFS_MODE, {15'h0, special});
      end
      cmd(c, b, ix, p1, 16'($urandom_range(0, 10)));
    end
    results();
  end
endmodule : fmv_sequencer_tb
